// ===== logic/clock_gen.sv
/*
 Clock generator control: APB registers, oscillator start and stop, sleep gating,
 system clock selection, clock output divider, auto-trim and operating modes.
 Assumes oscillator activity and source clocks arrive as asynchronous pins, CPU
 requests arrive on clk, and a glitch-free clock mux acts on the selection outputs.
*/
// The register offsets and the APB register port were decided locally.
`timescale 1ns/1ps
`include "clock_gen_regs.svh"

// Summary of operation
// - Key unlocks protected writes; other value relocks
// - High-speed stable flag set; write one clears
// - Type, wait, gain and frequency selects provided
// - Boot with internal oscillator as system clock
// - System clock from source and divider selects
// - Sleep stops only sources with stop bit
// - Wake switch loads wake source and divider
// - Without wake switch, selection stays unchanged
// - Clock pin outputs divided source when enabled
// - Auto-trim start self-clears, sets done flag
// - Low-speed stop sets flag, optional restart
// - Enable or detect falling also sets flag
// - Flag set and clock supplied in the same cycle after wait
// - Interrupt only for enabled set flags
// - Reset release enters RUN
// - Halt stops CPU, clocks keep running
// - Sleep stops CPU, RAM retained
// - Debug interrupt enters DEBUG, retd leaves
// - Three events return HALT or SLEEP to RUN; debug interrupt enters DEBUG
module clock_gen #(
	parameter int LS_WAIT     = 16384,
	parameter int TRIM_WINDOW = 32,
	parameter int TRIM_TARGET = 512,
	parameter int TRIM_ITERS  = 63
) (
	input  wire logic                      clk,
	input  wire logic                      rst_b,
	input  wire logic [7:0]                paddr,
	input  wire logic                      psel,
	input  wire logic                      penable,
	input  wire logic                      pwrite,
	input  wire logic [31:0]               pwdata,
	output logic      [31:0]               prdata,
	output logic                           pready,
	output logic                           pslverr,
	input  wire logic [3:0]                oscAlivePin,
	input  wire logic [3:0]                srcClkPin,
	input  wire clock_gen_pkg::cpu_req_t   cpuReq,
	input  wire clock_gen_pkg::wake_t      wake,
	output logic      [3:0]                oscEnable,
	output logic      [3:0]                oscSupply,
	output clock_gen_pkg::system_clock_t         system_clock,
	output clock_gen_pkg::hs_cfg_t         hsCfg,
	output logic      [5:0]                internalTrim,
	output logic                           clkoutPin,
	output logic                           cpuStopped,
	output logic                           ramHold,
	output logic                           clkIrq
);
	generate
		if (LS_WAIT < 1 || LS_WAIT > 131071 || TRIM_WINDOW < 1 || TRIM_WINDOW > 65535 ||
			TRIM_TARGET < 1 || TRIM_TARGET > 65535 || TRIM_ITERS < 1 || TRIM_ITERS > 255) begin : g_chk
			$error("clock_gen: parameter out of range");
		end
	endgenerate

	logic [15:0]                 prot_q;
	clock_gen_pkg::system_clock_t      sclk_q;
	clock_gen_pkg::system_clock_t      wup_q;
	logic                        wupMd_q;
	logic [3:0]                  en_q;
	logic [3:0]                  slp_q;
	clock_gen_pkg::hs_cfg_t      hs_q;
	logic                        coEn_q;
	logic [1:0]                  coSrc_q;
	logic [2:0]                  coDiv_q;
	logic [4:0]                  flag_q;
	logic [4:0]                  inte_q;
	logic                        detEn_q;
	logic                        rstEn_q;
	logic                        tStart_q;
	logic [31:0]                 prdata_q;
	logic                        slverr_q;
	clock_gen_pkg::mode_t        mode_q;
	clock_gen_pkg::mode_t        mode_d;
	logic [3:0]                  aliveS1_q, aliveS2_q;
	logic [3:0]                  srcS1_q, srcS2_q, srcS3_q;
	logic [3:0]                  srcEdge;
	logic [2:0]                  stable_q;
	logic [2:0]                  staRise;
	logic                        lsAliveD_q;
	logic                        lsStop;
	logic                        lsRestart;
	logic                        unlocked;
	logic                        apbWr;
	logic                        wakeAny;
	logic                        fromSleep;
	logic [4:0]                  flagSet;
	logic [4:0]                  flagClr;
	logic [6:0]                  coCnt_q;
	logic                        coPin_q;
	logic [15:0]                 winCnt_q;
	logic [15:0]                 tickCnt_q;
	logic [7:0]                  iter_q;
	logic [5:0]                  itrim_q;
	logic                        first_q;

	assign unlocked  = prot_q == `PROT_KEY;
	assign apbWr     = psel & penable & pwrite;
	assign wakeAny   = wake.periphIrq | wake.wdtNmi | wake.debugIrq | wake.resetReq;
	assign fromSleep = mode_q == clock_gen_pkg::SLEEP && mode_d != clock_gen_pkg::SLEEP;

	// Input synchronisers and source edge detection
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			aliveS1_q <= 4'h0;
			aliveS2_q <= 4'h0;
			srcS1_q   <= 4'h0;
			srcS2_q   <= 4'h0;
			srcS3_q   <= 4'h0;
		end else begin
			aliveS1_q <= oscAlivePin;
			aliveS2_q <= aliveS1_q;
			srcS1_q   <= srcClkPin;
			srcS2_q   <= srcS1_q;
			srcS3_q   <= srcS2_q;
		end
	end
	assign srcEdge = srcS2_q & ~srcS3_q;

	// Operating mode sequencing
	always_comb begin
		mode_d = mode_q;
		case (mode_q)
			clock_gen_pkg::RUN: begin
				if (wake.debugIrq) mode_d = clock_gen_pkg::DEBUG;
				else if (cpuReq.sleepReq) mode_d = clock_gen_pkg::SLEEP;
				else if (cpuReq.haltReq) mode_d = clock_gen_pkg::HALT;
			end
			clock_gen_pkg::HALT, clock_gen_pkg::SLEEP: begin
				if (wake.debugIrq) mode_d = clock_gen_pkg::DEBUG;
				else if (wakeAny) mode_d = clock_gen_pkg::RUN;
			end
			clock_gen_pkg::DEBUG: begin
				if (cpuReq.retd) mode_d = clock_gen_pkg::RUN;
			end
			default: mode_d = clock_gen_pkg::RUN;
		endcase
	end
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) mode_q <= clock_gen_pkg::RUN;
		else mode_q <= mode_d;
	end
	assign cpuStopped = mode_q == clock_gen_pkg::HALT || mode_q == clock_gen_pkg::SLEEP;
	assign ramHold    = mode_q == clock_gen_pkg::SLEEP;

	// Protection key
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) prot_q <= 16'h0000;
		else if (apbWr && paddr == `OFS_PROT) prot_q <= pwdata[`F_KEY];
	end

	// System clock selection with wake-up reload
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sclk_q  <= '{src: `SRC_INTERNAL, div: 2'h0};
			wup_q   <= '{src: `SRC_INTERNAL, div: 2'h0};
			wupMd_q <= 1'b0;
		end else begin
			if (apbWr && paddr == `OFS_SCLK && unlocked) begin
				sclk_q  <= '{src: pwdata[`F_SRC], div: pwdata[`F_DIV]};
				wup_q   <= '{src: pwdata[`F_WSRC], div: pwdata[`F_WDIV]};
				wupMd_q <= pwdata[`F_WMD];
			end
			if (fromSleep && wupMd_q) sclk_q <= wup_q;
		end
	end
	assign system_clock = sclk_q;

	// Oscillator enables, sleep stop bits and protected configuration
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			en_q    <= `OSC_EN_RESET;
			slp_q   <= `OSC_SLP_RESET;
			hs_q    <= '0;
			detEn_q <= 1'b0;
			rstEn_q <= 1'b0;
		end else begin
			if (apbWr && paddr == `OFS_OSC) begin
				en_q  <= pwdata[`F_EN];
				slp_q <= pwdata[`F_SLP];
			end
			if (apbWr && paddr == `OFS_HSCFG && unlocked) begin
				hs_q.oscType <= pwdata[`F_HTYPE];
				hs_q.waitSel <= pwdata[`F_HWAIT];
				hs_q.gain    <= pwdata[`F_HGAIN];
				hs_q.freq    <= pwdata[`F_HFREQ];
			end
			if (apbWr && paddr == `OFS_TRIM && unlocked) hs_q.trim <= pwdata[`F_HTRIM];
			if (apbWr && paddr == `OFS_LSCFG && unlocked) begin
				detEn_q <= pwdata[`F_DETEN];
				rstEn_q <= pwdata[`F_RSTEN];
			end
		end
	end
	assign hsCfg = hs_q;
	assign oscEnable = en_q & ~({4{mode_q == clock_gen_pkg::SLEEP}} & slp_q);

	// Stabilization wait for oscillators 0 to 2; oscillator 3 is supplied when enabled
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_osc
			logic [16:0] cnt_q;
			logic [16:0] target;
			if (gi == 0) begin : g_t0
				assign target = `INT_WAIT;
			end else if (gi == 1) begin : g_t1
				assign target = 17'(LS_WAIT);
			end else begin : g_t2
				assign target = `HS_WAIT_BASE << {hs_q.waitSel, 1'b0};
			end
			always_ff @(posedge clk or negedge rst_b) begin
				if (!rst_b) begin
					cnt_q       <= 17'h00000;
					stable_q[gi] <= 1'b0;
				end else if (!oscEnable[gi] || !aliveS2_q[gi] || (gi == 1 && lsRestart)) begin
					cnt_q       <= 17'h00000;
					stable_q[gi] <= 1'b0;
				end else if (!stable_q[gi]) begin
					if (cnt_q + 17'h00001 >= target) stable_q[gi] <= 1'b1;
					cnt_q <= cnt_q + 17'h00001;
				end
			end
			assign staRise[gi]   = oscEnable[gi] && aliveS2_q[gi] && !stable_q[gi] &&
				cnt_q + 17'h00001 >= target;
			assign oscSupply[gi] = stable_q[gi] & oscEnable[gi];
		end
	endgenerate
	assign oscSupply[3] = oscEnable[3];

	// Low-speed stop detection
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) lsAliveD_q <= 1'b0;
		else lsAliveD_q <= aliveS2_q[1];
	end
	assign lsStop = detEn_q && stable_q[1] && lsAliveD_q && !aliveS2_q[1];
	assign lsRestart = lsStop && rstEn_q;

	// Interrupt flags, set wins over write-one clear
	assign flagSet[`FL_INT_STA] = staRise[0];
	assign flagSet[`FL_LS_STA]  = staRise[1];
	assign flagSet[`FL_HS_STA]  = staRise[2];
	assign flagSet[`FL_LS_STOP] = lsStop || (apbWr && paddr == `OFS_OSC && en_q[`F_LS_EN] && !pwdata[`F_LS_EN]) ||
		(apbWr && paddr == `OFS_LSCFG && unlocked && detEn_q && !pwdata[`F_DETEN]);
	assign flagSet[`FL_TRIM]    = tStart_q && winCnt_q == 16'(TRIM_WINDOW) &&
		(tickCnt_q == 16'(TRIM_TARGET) || iter_q == 8'(TRIM_ITERS));
	assign flagClr = (apbWr && paddr == `OFS_INTF) ? pwdata[`F_FLAGS] : 5'h00;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			flag_q <= 5'h00;
			inte_q <= 5'h00;
		end else begin
			flag_q <= (flag_q & ~flagClr) | flagSet;
			if (apbWr && paddr == `OFS_INTE) inte_q <= pwdata[`F_FLAGS];
		end
	end
	assign clkIrq = |(flag_q & inte_q);

	// Auto-trim of the internal oscillator against low-speed edges
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			tStart_q  <= 1'b0;
			winCnt_q  <= 16'h0000;
			tickCnt_q <= 16'h0000;
			iter_q    <= 8'h00;
			itrim_q   <= `ITRIM_RESET;
		end else if (!tStart_q) begin
			winCnt_q  <= 16'h0000;
			tickCnt_q <= 16'h0000;
			iter_q    <= 8'h00;
			if (apbWr && paddr == `OFS_ATRIM && unlocked) tStart_q <= pwdata[`F_TSTART];
		end else if (winCnt_q == 16'(TRIM_WINDOW)) begin
			if (flagSet[`FL_TRIM]) tStart_q <= 1'b0;
			else if (tickCnt_q > 16'(TRIM_TARGET)) itrim_q <= itrim_q - 6'h01;
			else itrim_q <= itrim_q + 6'h01;
			iter_q    <= iter_q + 8'h01;
			winCnt_q  <= 16'h0000;
			tickCnt_q <= 16'h0000;
		end else begin
			if (srcEdge[1]) winCnt_q <= winCnt_q + 16'h0001;
			if (srcEdge[0]) tickCnt_q <= tickCnt_q + 16'h0001;
		end
	end
	assign internalTrim = itrim_q;

	// Clock output divider
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			coEn_q  <= 1'b0;
			coSrc_q <= 2'h0;
			coDiv_q <= 3'h0;
		end else if (apbWr && paddr == `OFS_CLKOUT) begin
			coEn_q  <= pwdata[`F_COEN];
			coSrc_q <= pwdata[`F_COSRC];
			coDiv_q <= pwdata[`F_CODIV];
		end
	end
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			coCnt_q <= 7'h00;
			coPin_q <= 1'b0;
		end else if (!coEn_q) begin
			coCnt_q <= 7'h00;
			coPin_q <= 1'b0;
		end else if (srcEdge[coSrc_q]) begin
			if (coCnt_q >= (7'h01 << coDiv_q) - 7'h01) begin
				coCnt_q <= 7'h00;
				coPin_q <= ~coPin_q;
			end else begin
				coCnt_q <= coCnt_q + 7'h01;
			end
		end
	end
	assign clkoutPin = coPin_q;

	// APB slave, read data captured in setup phase
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			prdata_q <= 32'h00000000;
			slverr_q <= 1'b0;
		end else if (psel && !penable) begin
			prdata_q <= 32'h00000000;
			slverr_q <= 1'b0;
			case (paddr)
				`OFS_PROT:   prdata_q[`F_KEY] <= prot_q;
				`OFS_SCLK: begin
					prdata_q[`F_SRC]  <= sclk_q.src;
					prdata_q[`F_DIV]  <= sclk_q.div;
					prdata_q[`F_WSRC] <= wup_q.src;
					prdata_q[`F_WDIV] <= wup_q.div;
					prdata_q[`F_WMD]  <= wupMd_q;
				end
				`OFS_OSC: begin
					prdata_q[`F_EN]  <= en_q;
					prdata_q[`F_SLP] <= slp_q;
				end
				`OFS_HSCFG: begin
					prdata_q[`F_HTYPE] <= hs_q.oscType;
					prdata_q[`F_HWAIT] <= hs_q.waitSel;
					prdata_q[`F_HGAIN] <= hs_q.gain;
					prdata_q[`F_HFREQ] <= hs_q.freq;
				end
				`OFS_TRIM:   prdata_q[`F_HTRIM] <= hs_q.trim;
				`OFS_CLKOUT: begin
					prdata_q[`F_COEN]  <= coEn_q;
					prdata_q[`F_COSRC] <= coSrc_q;
					prdata_q[`F_CODIV] <= coDiv_q;
				end
				`OFS_INTF:   prdata_q[`F_FLAGS] <= flag_q;
				`OFS_INTE:   prdata_q[`F_FLAGS] <= inte_q;
				`OFS_LSCFG: begin
					prdata_q[`F_DETEN] <= detEn_q;
					prdata_q[`F_RSTEN] <= rstEn_q;
				end
				`OFS_ATRIM:  prdata_q[`F_TSTART] <= tStart_q;
				`OFS_STATUS: prdata_q[`F_STATUS] <= {itrim_q, stable_q, unlocked};
				default:     slverr_q <= 1'b1;
			endcase
		end
	end
	assign prdata  = prdata_q;
	assign pready  = 1'b1;
	assign pslverr = slverr_q & psel & penable;

	// Checks
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) first_q <= 1'b1;
		else first_q <= 1'b0;
	end
	sequence s_leaveSleep;
		mode_q == clock_gen_pkg::SLEEP ##1 mode_q == clock_gen_pkg::RUN;
	endsequence
	a_locked_sclk: assert property (@(posedge clk) disable iff (!rst_b)
		apbWr && paddr == `OFS_SCLK && !unlocked && !fromSleep |=> $stable(sclk_q))
		else $error("locked write changed clock select");
	a_boot_internal: assert property (@(posedge clk) disable iff (!rst_b)
		first_q |-> system_clock.src == `SRC_INTERNAL)
		else $error("boot source not internal");
	a_sleep_gating: assert property (@(posedge clk) disable iff (!rst_b)
		mode_q == clock_gen_pkg::SLEEP |-> oscEnable == (en_q & ~slp_q))
		else $error("sleep gating wrong");
	a_wake_load: assert property (@(posedge clk) disable iff (!rst_b)
		wupMd_q ##0 s_leaveSleep |-> system_clock == $past(wup_q))
		else $error("wake values not loaded");
	a_wake_keep: assert property (@(posedge clk) disable iff (!rst_b)
		!wupMd_q && !apbWr ##0 s_leaveSleep |-> $stable(sclk_q))
		else $error("selection changed at wake");
	a_clkout_off: assert property (@(posedge clk) disable iff (!rst_b)
		!coEn_q |=> !clkoutPin)
		else $error("clock pin active while disabled");
	a_trim_done: assert property (@(posedge clk) disable iff (!rst_b)
		$fell(tStart_q) |-> flag_q[`FL_TRIM])
		else $error("trim end without done flag");
	a_irq_gate: assert property (@(posedge clk) disable iff (!rst_b)
		clkIrq == |(flag_q & inte_q))
		else $error("interrupt request mismatch");
	a_supply_after: assert property (@(posedge clk) disable iff (!rst_b)
		$rose(oscSupply[2]) |-> flag_q[`FL_HS_STA] || $past(flagClr[`FL_HS_STA]))
		else $error("clock supplied before flag");
	a_stop_wake: assert property (@(posedge clk) disable iff (!rst_b)
		cpuStopped && wakeAny && !wake.debugIrq |=> mode_q == clock_gen_pkg::RUN)
		else $error("no wake to run");
	a_debug_enter: assert property (@(posedge clk) disable iff (!rst_b)
		mode_q != clock_gen_pkg::DEBUG && wake.debugIrq |=> mode_q == clock_gen_pkg::DEBUG)
		else $error("debug entry missed");
endmodule : clock_gen

// ===== inc/clock_gen_regs.svh
/*
 Register offsets, field positions, reset values and timing counts for the clock generator.
 Assumes byte addresses on an APB bus with 32-bit data, one register per aligned word.
*/
`ifndef CLOCK_GEN_REGS_SVH
`define CLOCK_GEN_REGS_SVH
`define OFS_PROT    8'h00
`define OFS_SCLK    8'h04
`define OFS_OSC     8'h08
`define OFS_HSCFG   8'h0C
`define OFS_TRIM    8'h10
`define OFS_CLKOUT  8'h14
`define OFS_INTF    8'h18
`define OFS_INTE    8'h1C
`define OFS_LSCFG   8'h20
`define OFS_ATRIM   8'h24
`define OFS_STATUS  8'h28
`define PROT_KEY    16'h0096
`define SRC_INTERNAL 2'h0
`define F_KEY       15:0
`define F_SRC       1:0
`define F_DIV       5:4
`define F_WSRC      9:8
`define F_WDIV      13:12
`define F_WMD       15
`define F_EN        3:0
`define F_SLP       11:8
`define F_HTYPE     1:0
`define F_HWAIT     6:4
`define F_HGAIN     9:8
`define F_HFREQ     14:12
`define F_HTRIM     4:0
`define F_COEN      0
`define F_COSRC     5:4
`define F_CODIV     10:8
`define F_FLAGS     4:0
`define F_DETEN     0
`define F_RSTEN     1
`define F_TSTART    0
`define FL_INT_STA  0
`define FL_LS_STA   1
`define FL_HS_STA   2
`define FL_LS_STOP  3
`define FL_TRIM     4
`define INT_WAIT    17'h00010
`define HS_WAIT_BASE 17'h00004
`define ITRIM_RESET 6'h20
`define OSC_EN_RESET  4'h1
`define OSC_SLP_RESET 4'hF
`define F_LS_EN     1
`define F_STATUS    9:0
`endif

// ===== inc/clock_gen_pkg.sv
/*
 Types shared by the clock generator: operating modes and grouped signals.
 Assumes the register header supplies all numbers.
*/
package clock_gen_pkg;
	typedef enum logic [1:0] {RUN, HALT, SLEEP, DEBUG} mode_t;
	typedef struct packed {
		logic [1:0] src;
		logic [1:0] div;
	} system_clock_t;
	typedef struct packed {
		logic haltReq;
		logic sleepReq;
		logic retd;
	} cpu_req_t;
	typedef struct packed {
		logic periphIrq;
		logic wdtNmi;
		logic debugIrq;
		logic resetReq;
	} wake_t;
	typedef struct packed {
		logic [1:0] oscType;
		logic [2:0] waitSel;
		logic [1:0] gain;
		logic [2:0] freq;
		logic [4:0] trim;
	} hs_cfg_t;
endpackage : clock_gen_pkg

// ===== testbench/osc_far_side.sv
/*
 Behavioural oscillators on the far side of the clock generator.
 Assumes oscEnable from the design and a stop request from the bench.
*/
`timescale 1ns/1ps
module osc_far_side (
	input  wire logic       clk,
	input  wire logic [3:0] oscEnable,
	input  wire logic       lsKill,
	output logic      [3:0] oscAlivePin,
	output logic      [3:0] srcClkPin
);
	logic [1:0] phase_q;
	initial phase_q = 2'h0;
	// Oscillation only while enabled; stop request kills low-speed
	assign oscAlivePin = oscEnable & {2'h3, ~lsKill, 1'h1};
	always_ff @(posedge clk) begin
		phase_q <= phase_q + 2'h1;
	end
	// Stopped sources stay low, running ones toggle every two cycles
	assign srcClkPin = oscAlivePin & {4{phase_q[1]}};
endmodule : osc_far_side

// ===== testbench/clock_gen_and_power_modes_tb.sv
/*
 Self-checking bench for the clock generator: APB master, CPU and wake pulses.
 Assumes the oscillator model in osc_far_side and zero-wait APB answers.
*/
`timescale 1ns/1ps
`include "clock_gen_regs.svh"
module clock_gen_and_power_modes_tb;
	logic                    clk, rst_b, psel, penable, pwrite, lsKill;
	logic [7:0]              paddr;
	logic [31:0]             pwdata, prdata;
	logic                    pready, pslverr, clkoutPin, cpuStopped, ramHold, clkIrq;
	logic [3:0]              oscAlivePin, srcClkPin, oscEnable, oscSupply;
	logic [5:0]              internalTrim;
	clock_gen_pkg::cpu_req_t cpuReq;
	clock_gen_pkg::wake_t    wake;
	clock_gen_pkg::system_clock_t  system_clock;
	clock_gen_pkg::hs_cfg_t  hsCfg;
	int                      n_fail, compares;

	clock_gen #(.LS_WAIT(8), .TRIM_WINDOW(4), .TRIM_TARGET(8), .TRIM_ITERS(4)) clock_gen_inst (
		.clk, .rst_b, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
		.oscAlivePin, .srcClkPin, .cpuReq, .wake, .oscEnable, .oscSupply, .system_clock, .hsCfg,
		.internalTrim, .clkoutPin, .cpuStopped, .ramHold, .clkIrq);
	osc_far_side osc_far_side_inst (.clk, .oscEnable, .lsKill, .oscAlivePin, .srcClkPin);

	always #2.5 clk = ~clk;

	task automatic conclude();
		$display("comparisons %0d mismatches %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : conclude

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		compares++;
		if (got !== exp) begin
			n_fail++;
			$display("wrong value at %0t: %s got %h expected %h", $time, m, got, exp);
		end
	endtask : chk

	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d,
			output logic [31:0] r, output logic e);
		@(posedge clk);
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		psel <= 1'h1;
		penable <= 1'h0;
		@(posedge clk);
		penable <= 1'h1;
		do begin
			@(posedge clk);
		end while (pready !== 1'h1);
		r = prdata;
		e = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		// Let register updates settle before outputs are compared
		@(negedge clk);
	endtask : apb

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		apb(a, 1'h1, d, r, e);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] mask, input logic [31:0] exp, input string m);
		logic [31:0] r;
		logic        e;
		apb(a, 1'h0, 32'h0, r, e);
		chk(r & mask, exp, m);
	endtask : rd

	task automatic poll(input logic [7:0] a, input int b, input logic v, input string m);
		logic [31:0] r;
		logic        e;
		int          n;
		n = 0;
		do begin
			apb(a, 1'h0, 32'h0, r, e);
			n++;
		end while (r[b] !== v && n < 200);
		chk({31'h0, r[b]}, {31'h0, v}, m);
	endtask : poll

	task automatic pulse(input logic [2:0] c, input logic [3:0] w);
		@(posedge clk);
		cpuReq <= c;
		wake <= w;
		@(posedge clk);
		cpuReq <= 3'h0;
		wake <= 4'h0;
		repeat (2) @(posedge clk);
	endtask : pulse

	initial begin
		repeat (20000) @(posedge clk);
		n_fail++;
		conclude();
	end

	initial begin
		logic [31:0] r;
		logic        e, prev;
		int          n;
		{clk, psel, penable, pwrite, lsKill, paddr, pwdata} = '0;
		{rst_b, cpuReq, wake, n_fail, compares} = '0;
		repeat (20) @(posedge clk);
		rst_b <= 1'h1;
		@(posedge clk);
		chk({28'h0, system_clock}, 32'h0, "boot clock");
		chk({31'h0, cpuStopped}, 32'h0, "run after reset");
		rd(`OFS_OSC, 32'hFFFF, 32'h0F01, "osc reset");
		wr(`OFS_SCLK, 32'h0012);
		rd(`OFS_SCLK, 32'hFFFF, 32'h0, "locked write");
		wr(`OFS_PROT, 32'h0096);
		rd(`OFS_STATUS, 32'h1, 32'h1, "unlocked");
		wr(`OFS_SCLK, 32'h0012);
		chk({28'h0, system_clock}, 32'h9, "source and divider");
		wr(`OFS_HSCFG, 32'h3201);
		wr(`OFS_TRIM, 32'h0015);
		chk({17'h0, hsCfg}, 32'h2275, "hs config");
		wr(`OFS_PROT, 32'h0);
		wr(`OFS_SCLK, 32'h0003);
		rd(`OFS_SCLK, 32'hFFFF, 32'h0012, "relocked");
		apb(8'h3C, 1'h0, 32'h0, r, e);
		chk({e, r[30:0]}, 32'h80000000, "unmapped");
		poll(`OFS_INTF, 0, 1'h1, "internal stable");
		chk({28'h0, oscSupply}, 32'h1, "internal supply");
		wr(`OFS_INTE, 32'h1);
		chk({31'h0, clkIrq}, 32'h1, "irq enabled flag");
		wr(`OFS_INTF, 32'h1);
		chk({31'h0, clkIrq}, 32'h0, "flag cleared");
		wr(`OFS_INTE, 32'h4);
		wr(`OFS_OSC, 32'h0F07);
		poll(`OFS_INTF, 2, 1'h1, "hs stable");
		chk({31'h0, clkIrq}, 32'h1, "hs irq");
		chk({31'h0, oscSupply[2]}, 32'h1, "hs supply");
		poll(`OFS_INTF, 1, 1'h1, "ls stable");
		wr(`OFS_INTF, 32'h1F);
		wr(`OFS_CLKOUT, 32'h0111);
		n = 0;
		prev = clkoutPin;
		repeat (160) begin
			@(posedge clk);
			if (clkoutPin === 1'h1 && prev === 1'h0)
				n++;
			prev = clkoutPin;
		end
		chk({31'h0, n >= 9 && n <= 11}, 32'h1, "clock out rate");
		wr(`OFS_CLKOUT, 32'h0110);
		repeat (4) @(posedge clk);
		chk({31'h0, clkoutPin}, 32'h0, "clock out off");
		wr(`OFS_OSC, 32'h0407);
		wr(`OFS_PROT, 32'h0096);
		wr(`OFS_SCLK, 32'hA312);
		pulse(3'h2, 4'h0);
		chk({30'h0, ramHold, cpuStopped}, 32'h3, "sleep");
		chk({28'h0, oscEnable}, 32'h3, "sleep gating");
		pulse(3'h0, 4'h8);
		chk({28'h0, system_clock}, 32'hE, "wake switch");
		chk({28'h0, oscEnable}, 32'h7, "sources back");
		rd(`OFS_SCLK, 32'h33, 32'h23, "wake copy");
		wr(`OFS_SCLK, 32'h3312);
		pulse(3'h2, 4'h0);
		pulse(3'h0, 4'h8);
		chk({28'h0, system_clock}, 32'h9, "no wake switch");
		for (int i = 0; i < 4; i++) begin
			pulse(3'h4, 4'h0);
			chk({29'h0, oscEnable[2:0]}, 32'h7, "halt keeps clocks");
			chk({30'h0, ramHold, cpuStopped}, 32'h1, "halt");
			pulse(3'h0, 4'h1 << i);
			chk({31'h0, cpuStopped}, 32'h0, "halt cancel");
			if (i == 1)
				pulse(3'h1, 4'h0);
		end
		wr(`OFS_LSCFG, 32'h3);
		@(posedge clk);
		lsKill <= 1'h1;
		poll(`OFS_INTF, 3, 1'h1, "ls stop");
		wr(`OFS_INTF, 32'hA);
		@(posedge clk);
		lsKill <= 1'h0;
		poll(`OFS_INTF, 1, 1'h1, "ls restart");
		wr(`OFS_INTF, 32'hA);
		wr(`OFS_OSC, 32'h0405);
		rd(`OFS_INTF, 32'h8, 32'h8, "ls disable flag");
		wr(`OFS_OSC, 32'h0407);
		poll(`OFS_INTF, 1, 1'h1, "ls stable again");
		wr(`OFS_INTF, 32'h10);
		wr(`OFS_ATRIM, 32'h1);
		poll(`OFS_ATRIM, 0, 1'h0, "trim start clears");
		rd(`OFS_INTF, 32'h10, 32'h10, "trim done");
		chk({26'h0, internalTrim}, 32'h24, "trim steps");
		wr(`OFS_INTF, 32'h8);
		wr(`OFS_LSCFG, 32'h0);
		rd(`OFS_INTF, 32'h8, 32'h8, "detect disable flag");
		wr(`OFS_PROT, 32'h0);
		conclude();
	end
endmodule : clock_gen_and_power_modes_tb
